// ---- rtl/irc_codec.sv ----
// Functional notes
// (RQ1) State machines step on 16x baud tick
// (RQ2) Clock select high picks external baud clock
// (RQ3) Rate code sets crystal divide ratio
// (RQ4) Rate codes cover 115200 down to 2400
// (RQ5) Host sets rate before traffic starts
// (RQ6) Serial falling edge starts transmit modulation
// (RQ7) Optical falling edge starts receive stretch
// (RQ8) Reset low holds decoder in reset
// (RQ9) Reset low ignores optical input, output idle
// (RQ10) Fixed mode: six crystal cycle pulse
// (RQ11) Fixed pulse length ignores rate select
// (RQ12) Fixed mode only with internal clock
// (RQ13) Undriven fixed mode input reads low
// (RQ14) Power-down stops internal baud ticks
// (RQ15) Wait seven ticks, pulse three ticks
// (RQ16) One pulse per zero bit, none for one
// (RQ17) Stretch each pulse to sixteen ticks low
// (RQ18) External clock select powers oscillator down
// (RQ19) Idle: optical out low, serial out high
// (RQ20) New optical edge restarts stretch count
`timescale 1ns/100ps
`default_nettype none

module irc_codec #(
    parameter int FIFO_DEPTH = 2,
    parameter int FIFO_WIDTH = $bits(irc_pkg::irc_tx_evt_t)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic baud16_clock_in_i,
    input wire logic ext_clock_select_i,
    input wire logic [2:0] rate_select_i,
    input wire logic fixed_width_pulse_mode_i,
    input wire logic osc_powerdown_i,
    input wire logic decoder_reset_n_i,
    input wire logic uart_serial_in_i,
    input wire logic optical_pulse_in_i,
    output logic optical_pulse_out_o,
    output logic uart_serial_out_o,
    output logic tx_event_ready_o,
    output logic osc_running_o
);
    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

    // ==========================================================
    // Divide ratio lookup
    // ==========================================================
    function automatic logic [6:0] div_ratio(input logic [2:0] code);
        logic [6:0] r;
        r = irc_pkg::DIV_NONE;
        unique case (code)
            irc_pkg::RATE_115200: r = irc_pkg::DIV_BY_2;
            irc_pkg::RATE_57600: r = irc_pkg::DIV_BY_4;
            irc_pkg::RATE_19200: r = irc_pkg::DIV_BY_12;
            irc_pkg::RATE_9600: r = irc_pkg::DIV_BY_24;
            irc_pkg::RATE_38400: r = irc_pkg::DIV_BY_6;
            irc_pkg::RATE_4800: r = irc_pkg::DIV_BY_48;
            irc_pkg::RATE_2400: r = irc_pkg::DIV_BY_96;
            irc_pkg::RATE_TEST: r = irc_pkg::DIV_NONE;
        endcase
        return r;
    endfunction : div_ratio

    // ==========================================================
    // Baud tick generation
    // ==========================================================
    logic [6:0] div_cnt_q;
    logic [6:0] div_cnt_d;
    logic [6:0] div_n;
    logic osc_run;
    logic int_tick;
    logic ext_prev_q;
    logic ext_rise;
    logic baud_tick;

    // Oscillator stops on power-down or when external clock chosen
    assign osc_run = ~osc_powerdown_i & ~ext_clock_select_i; // [RQ14] [RQ18]
    // Rate is sampled live; the host must settle it before traffic
    assign div_n = div_ratio(rate_select_i); // [RQ3] [RQ4] [RQ5]
    assign int_tick = osc_run && (div_cnt_q >= div_n - 7'h01);
    // Held at zero while stopped, so a restart begins a full period
    assign div_cnt_d = (!osc_run || int_tick) ? 7'h00 : div_cnt_q + 7'h01;
    // External clock is sampled, so it must run below half of clk_i
    assign ext_rise = baud16_clock_in_i & ~ext_prev_q; // [RQ1]
    assign baud_tick = ext_clock_select_i ? ext_rise : int_tick; // [RQ2]

    // Divider and external clock edge history
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_q <= 7'h00;
            ext_prev_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            ext_prev_q <= baud16_clock_in_i;
        end
    end

    // ==========================================================
    // Transmit start buffer
    // ==========================================================
    logic txd_prev_q;
    logic txd_fall;
    logic [FIFO_WIDTH-1:0] fifo_mem_q [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0] fifo_cnt_q;
    logic fifo_full;
    logic fifo_empty;
    logic push;
    logic pop;
    irc_pkg::irc_tx_evt_t push_evt;
    irc_pkg::irc_tx_evt_t head_evt;

    // Undriven mode pin is pulled low at the pad, so it reads as low
    assign push_evt.fixed_width = fixed_width_pulse_mode_i & ~ext_clock_select_i; // [RQ12] [RQ13]
    assign push_evt.ext_clock = ext_clock_select_i;
    assign txd_fall = txd_prev_q & ~uart_serial_in_i; // [RQ6]
    assign fifo_full = (fifo_cnt_q == (PTR_W + 1)'(FIFO_DEPTH));
    assign fifo_empty = (fifo_cnt_q == '0);
    // A start edge seen while full is dropped; ready shows it
    assign push = txd_fall & ~fifo_full;
    assign head_evt = fifo_mem_q[rd_ptr_q];

    // Pointer wrap helper
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    // Buffer pointers and occupancy
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txd_prev_q <= 1'b1;
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            fifo_cnt_q <= '0;
        end else begin
            txd_prev_q <= uart_serial_in_i;
            if (push) wr_ptr_q <= ptr_inc(wr_ptr_q);
            if (pop) rd_ptr_q <= ptr_inc(rd_ptr_q);
            fifo_cnt_q <= fifo_cnt_q + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
        end
    end

    // Storage has no reset; reads are gated by occupancy
    always_ff @(posedge clk_i) begin
        if (push) fifo_mem_q[wr_ptr_q] <= push_evt;
    end

    // ==========================================================
    // Encoder
    // ==========================================================
    irc_pkg::irc_enc_state_t enc_state_q;
    irc_pkg::irc_enc_state_t enc_state_d;
    logic [3:0] enc_cnt_q;
    logic [3:0] enc_cnt_d;
    logic enc_fixed_q;
    logic enc_mod;
    logic enc_bit_end;
    logic enc_mid;
    logic enc_first_q;
    logic mod_prev_q;
    logic mono_start;
    logic [2:0] mono_cnt_q;
    logic [2:0] mono_cnt_d;
    logic opt_out_d;

    // Buffer drains only into an idle encoder
    assign pop = ~fifo_empty & (enc_state_q == irc_pkg::ENC_IDLE);
    assign enc_bit_end = baud_tick & (enc_cnt_q == irc_pkg::BIT_LAST_TICK);
    // Decision tick sits mid-bit, clear of the line's own edges
    assign enc_mid = baud_tick & (enc_cnt_q == irc_pkg::ENC_DELAY_TICKS - 4'h1);
    // High after seven ticks for three ticks, centred in the bit
    assign enc_mod = (enc_state_q == irc_pkg::ENC_RUN)
        && (enc_cnt_q >= irc_pkg::ENC_DELAY_TICKS)
        && (enc_cnt_q < irc_pkg::ENC_DELAY_TICKS + irc_pkg::ENC_PULSE_TICKS); // [RQ15]

    // Encoder next state; from the second bit on, a high line at
    // mid-bit means a one bit and ends the run without a pulse.
    // Sampling at the bit boundary would race the serial line's own
    // transition whenever the divide ratio is above two.
    always_comb begin
        enc_state_d = enc_state_q;
        enc_cnt_d = enc_cnt_q;
        unique case (enc_state_q)
            irc_pkg::ENC_IDLE: begin
                if (pop) begin
                    enc_state_d = irc_pkg::ENC_RUN; // [RQ6]
                    enc_cnt_d = 4'h0;
                end
            end
            irc_pkg::ENC_RUN: begin
                if (baud_tick) enc_cnt_d = enc_cnt_q + 4'h1; // [RQ1]
                if (enc_mid && !enc_first_q && uart_serial_in_i) begin
                    enc_state_d = irc_pkg::ENC_IDLE; // [RQ16]
                    enc_cnt_d = 4'h0;
                end
            end
            default: begin
                enc_state_d = irc_pkg::ENC_IDLE;
                enc_cnt_d = 4'h0;
            end
        endcase
    end

    // Fixed mode: six crystal cycles from the modulation rising edge
    assign mono_start = enc_mod & ~mod_prev_q & enc_fixed_q; // [RQ10]
    assign mono_cnt_d = mono_start ? irc_pkg::MONO_CYCLES
        : (mono_cnt_q != 3'h0) ? mono_cnt_q - 3'h1 : 3'h0; // [RQ11]
    assign opt_out_d = enc_fixed_q ? (mono_cnt_d != 3'h0) : enc_mod; // [RQ19]

    // Encoder registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enc_state_q <= irc_pkg::ENC_IDLE;
            enc_cnt_q <= 4'h0;
            enc_fixed_q <= 1'b0;
            enc_first_q <= 1'b0;
            mod_prev_q <= 1'b0;
            mono_cnt_q <= 3'h0;
            optical_pulse_out_o <= 1'b0;
        end else begin
            enc_state_q <= enc_state_d;
            enc_cnt_q <= enc_cnt_d;
            if (pop) enc_fixed_q <= head_evt.fixed_width;
            // First bit is always a zero: the start edge itself
            if (pop) enc_first_q <= 1'b1;
            else if (enc_bit_end) enc_first_q <= 1'b0;
            mod_prev_q <= enc_mod;
            mono_cnt_q <= mono_cnt_d;
            optical_pulse_out_o <= opt_out_d;
        end
    end

    // ==========================================================
    // Decoder
    // ==========================================================
    irc_pkg::irc_dec_state_t dec_state_q;
    irc_pkg::irc_dec_state_t dec_state_d;
    logic [3:0] dec_cnt_q;
    logic [3:0] dec_cnt_d;
    logic opt_prev_q;
    logic opt_fall;

    assign opt_fall = opt_prev_q & ~optical_pulse_in_i; // [RQ7]

    // Reset wins, then a fresh edge, then the count
    always_comb begin
        dec_state_d = dec_state_q;
        dec_cnt_d = dec_cnt_q;
        if (!decoder_reset_n_i) begin
            dec_state_d = irc_pkg::DEC_IDLE; // [RQ8] [RQ9]
            dec_cnt_d = 4'h0;
        end else if (opt_fall) begin
            dec_state_d = irc_pkg::DEC_STRETCH; // [RQ7] [RQ20]
            dec_cnt_d = 4'h0;
        end else begin
            unique case (dec_state_q)
                irc_pkg::DEC_IDLE: dec_cnt_d = 4'h0;
                irc_pkg::DEC_STRETCH: begin
                    if (baud_tick) begin
                        dec_cnt_d = dec_cnt_q + 4'h1;
                        if (dec_cnt_q == irc_pkg::BIT_LAST_TICK) begin
                            dec_state_d = irc_pkg::DEC_IDLE; // [RQ17]
                        end
                    end
                end
                default: begin
                    dec_state_d = irc_pkg::DEC_IDLE;
                    dec_cnt_d = 4'h0;
                end
            endcase
        end
    end

    // Decoder registers; output is low only while stretching.
    // Optical history resets dark, matching the idle input, so the
    // release of reset cannot fake a pulse end.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dec_state_q <= irc_pkg::DEC_IDLE;
            dec_cnt_q <= 4'h0;
            opt_prev_q <= 1'b0;
            uart_serial_out_o <= 1'b1;
            tx_event_ready_o <= 1'b0;
            osc_running_o <= 1'b0;
        end else begin
            dec_state_q <= dec_state_d;
            dec_cnt_q <= dec_cnt_d;
            opt_prev_q <= optical_pulse_in_i;
            uart_serial_out_o <= (dec_state_d == irc_pkg::DEC_IDLE); // [RQ19]
            tx_event_ready_o <= ~fifo_full;
            osc_running_o <= osc_run;
        end
    end
endmodule : irc_codec

`default_nettype wire

// ---- rtl/irc_pkg.sv ----
package irc_pkg;
    // ==========================================================
    // Encoder and decoder timing, in baud ticks
    // ==========================================================
    localparam logic [3:0] ENC_DELAY_TICKS = 4'h7;
    localparam logic [3:0] ENC_PULSE_TICKS = 4'h3;
    localparam logic [3:0] BIT_LAST_TICK = 4'hF;
    localparam int BAUD_MULT = 16;

    // ==========================================================
    // Fixed-width mode length, in crystal (clk_i) cycles
    // ==========================================================
    localparam logic [2:0] MONO_CYCLES = 3'h6;

    // ==========================================================
    // Rate select codes and crystal divide ratios
    // ==========================================================
    localparam logic [2:0] RATE_115200 = 3'h0;
    localparam logic [2:0] RATE_57600 = 3'h1;
    localparam logic [2:0] RATE_19200 = 3'h2;
    localparam logic [2:0] RATE_9600 = 3'h3;
    localparam logic [2:0] RATE_38400 = 3'h4;
    localparam logic [2:0] RATE_4800 = 3'h5;
    localparam logic [2:0] RATE_2400 = 3'h6;
    localparam logic [2:0] RATE_TEST = 3'h7;
    localparam logic [6:0] DIV_BY_2 = 7'h02;
    localparam logic [6:0] DIV_BY_4 = 7'h04;
    localparam logic [6:0] DIV_BY_12 = 7'h0C;
    localparam logic [6:0] DIV_BY_24 = 7'h18;
    localparam logic [6:0] DIV_BY_6 = 7'h06;
    localparam logic [6:0] DIV_BY_48 = 7'h30;
    localparam logic [6:0] DIV_BY_96 = 7'h60;
    localparam logic [6:0] DIV_NONE = 7'h01;

    // ==========================================================
    // State machines
    // ==========================================================
    typedef enum logic [1:0] {
        ENC_IDLE = 2'b01,
        ENC_RUN = 2'b10
    } irc_enc_state_t;

    typedef enum logic [1:0] {
        DEC_IDLE = 2'b01,
        DEC_STRETCH = 2'b10
    } irc_dec_state_t;

    // ==========================================================
    // Transmit start event carried through the buffer
    // ==========================================================
    typedef struct packed {
        logic fixed_width;
        logic ext_clock;
    } irc_tx_evt_t;
endpackage : irc_pkg

// ---- test/irc_codec_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port-level watch on the codec
// ==========================================
module irc_codec_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic baud16_clock_in_i,
    input wire logic ext_clock_select_i,
    input wire logic [2:0] rate_select_i,
    input wire logic fixed_width_pulse_mode_i,
    input wire logic osc_powerdown_i,
    input wire logic decoder_reset_n_i,
    input wire logic uart_serial_in_i,
    input wire logic optical_pulse_in_i,
    input wire logic optical_pulse_out_o,
    input wire logic uart_serial_out_o,
    input wire logic tx_event_ready_o,
    input wire logic osc_running_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Tick on every clock: widths are exact counts
    wire fast_w = (rate_select_i == 3'h7) && !ext_clock_select_i && !osc_powerdown_i;
    wire fix_w = fixed_width_pulse_mode_i && !ext_clock_select_i;
    // Idle levels checked while reset is held, so no disable here
    AST_RESET_IDLE: assert property (disable iff (1'b0) rst_i |-> !optical_pulse_out_o && uart_serial_out_o)
        else $error("outputs not idle in reset");
    AST_DECRST_MARK: assert property (!decoder_reset_n_i |=> uart_serial_out_o)
        else $error("receive output left mark under decoder reset");
    AST_RX_START: assert property ($fell(optical_pulse_in_i) && decoder_reset_n_i |=> !uart_serial_out_o)
        else $error("optical edge did not start stretch");
    AST_RX_HOLD: assert property ($fell(optical_pulse_in_i) && decoder_reset_n_i && fast_w
        |=> !uart_serial_out_o [*8] ##1 !uart_serial_out_o [*8])
        else $error("stretch ended early");
    AST_TX_WIDTH: assert property ($rose(optical_pulse_out_o) && fast_w && !fixed_width_pulse_mode_i
        |-> optical_pulse_out_o [*3] ##1 !optical_pulse_out_o)
        else $error("normal pulse not three ticks");
    AST_FIXED_WIDTH: assert property ($rose(optical_pulse_out_o) && fix_w
        |-> optical_pulse_out_o [*6] ##1 !optical_pulse_out_o)
        else $error("fixed pulse not six clocks");
    AST_OSC_RUN: assert property (1'b1 |=> osc_running_o == $past(!ext_clock_select_i && !osc_powerdown_i))
        else $error("oscillator state wrong");
    AST_PD_NO_TICK: assert property ((osc_powerdown_i && !ext_clock_select_i) [*4] |-> !$rose(optical_pulse_out_o))
        else $error("pulse while oscillator down");
    // Main scenarios reached
    cover property ($fell(uart_serial_out_o));
    cover property ($rose(optical_pulse_out_o) && fix_w);
    cover property ($fell(tx_event_ready_o));
endmodule : irc_codec_checker

bind irc_codec irc_codec_checker u_chk (.*);
`default_nettype wire

// ---- test/irc_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// UART transmitter and optical front end
// ==========================================
module irc_partner (
    input wire logic clk_i,
    output logic txd_o,
    output logic opt_o
);
    // Idle at mark and dark
    initial begin
        txd_o = 1'b1;
        opt_o = 1'b0;
    end
    // LSB first, each bit held for clks clocks
    task automatic send_bits(input logic [7:0] bits, input int n, input int clks);
        for (int i = 0; i < n; i++) begin
            txd_o <= bits[i];
            repeat (clks) @(posedge clk_i);
        end
        txd_o <= 1'b1;
    endtask : send_bits
    // Light pulse; its falling edge is what counts
    task automatic flash(input int len);
        opt_o <= 1'b1;
        repeat (len) @(posedge clk_i);
        opt_o <= 1'b0;
    endtask : flash
endmodule : irc_partner
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Codec bench
// ==========================================
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b0;
    logic [1:0] bcnt = 2'h0;
    logic baud16_clock_in_i;
    logic ext_clock_select_i = 1'b0;
    logic [2:0] rate_select_i = 3'h7;
    logic fixed_width_pulse_mode_i = 1'b0;
    logic osc_powerdown_i = 1'b0;
    logic decoder_reset_n_i = 1'b1;
    logic uart_serial_in_i, optical_pulse_in_i;
    logic optical_pulse_out_o, uart_serial_out_o, tx_event_ready_o, osc_running_o;
    int err_count = 0;
    int compares = 0;
    int hi_len = 0, lo_len = 0, last_hi = 0, last_lo = 0, npulse = 0, since = 0, rise_at = 0;
    logic txd_p = 1'b1, out_p = 1'b0;
    int divs[8] = '{2, 4, 12, 24, 6, 48, 96, 1};

    always #20 clk_i = ~clk_i;
    // External baud clock: one rising edge every four clocks
    always @(posedge clk_i) bcnt <= bcnt + 2'h1;
    assign baud16_clock_in_i = bcnt[1];

    irc_codec dut (.*);
    irc_partner p (.clk_i(clk_i), .txd_o(uart_serial_in_i), .opt_o(optical_pulse_in_i));

    // Widths and delays measured in clocks from sampled levels
    always @(posedge clk_i) begin
        since = (txd_p && !uart_serial_in_i) ? 0 : since + 1;
        if (optical_pulse_out_o && !out_p) rise_at = since;
        if (optical_pulse_out_o) hi_len++;
        else if (hi_len > 0) begin
            last_hi = hi_len;
            npulse++;
            hi_len = 0;
        end
        if (!uart_serial_out_o) lo_len++;
        else if (lo_len > 0) begin
            last_lo = lo_len;
            lo_len = 0;
        end
        txd_p = uart_serial_in_i;
        out_p = optical_pulse_out_o;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    // One frame, then a quiet spell long enough for the last pulse
    task automatic tx_frame(input logic [7:0] bits, input int n, input int tk, input int w, input int np);
        npulse = 0;
        p.send_bits(bits, n, 16 * tk);
        repeat (32 * tk) @(posedge clk_i);
        check(npulse, np);
        if (np > 0) check(last_hi, w);
    endtask : tx_frame

    task automatic rx_pair(input int gap, input int exp);
        p.flash(3);
        if (gap > 0) begin
            repeat (gap - 3) @(posedge clk_i);
            p.flash(3);
        end
        repeat (40) @(posedge clk_i);
        check(last_lo, exp);
    endtask : rx_pair

    initial begin
        // Reset edge at time zero, so outputs are idle at the first clock
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        check({optical_pulse_out_o, uart_serial_out_o, tx_event_ready_o}, 3'h2);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Rate set while the line is idle, before each frame
        for (int c = 0; c < 8; c++) begin
            rate_select_i <= c[2:0];
            @(posedge clk_i);
            tx_frame(8'h00, 1, divs[c], 3 * divs[c], 1);
        end
        check(rise_at, 32'(irc_pkg::ENC_DELAY_TICKS) + 3);
        tx_frame(8'h04, 4, 1, 3, 3);
        rx_pair(0, irc_pkg::BAUD_MULT);
        rx_pair(8, 8 + irc_pkg::BAUD_MULT);
        rate_select_i <= 3'h6;
        fixed_width_pulse_mode_i <= 1'b1;
        @(posedge clk_i);
        tx_frame(8'h00, 1, 96, 6, 1);
        rate_select_i <= 3'h0;
        @(posedge clk_i);
        tx_frame(8'h00, 1, 2, 6, 1);
        // Fixed mode is dropped in the same cycle the external clock is chosen
        fixed_width_pulse_mode_i <= 1'b0;
        ext_clock_select_i <= 1'b1;
        @(posedge clk_i);
        // External clock in normal mode; pulse is three external ticks
        tx_frame(8'h00, 1, 4, 12, 1);
        check(osc_running_o, 1'b0);
        ext_clock_select_i <= 1'b0;
        fixed_width_pulse_mode_i <= 1'b0;
        rate_select_i <= 3'h7;
        osc_powerdown_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check(osc_running_o, 1'b0);
        tx_frame(8'h00, 1, 1, 0, 0);
        osc_powerdown_i <= 1'b0;
        repeat (64) @(posedge clk_i);
        check(osc_running_o, 1'b1);
        decoder_reset_n_i <= 1'b0;
        @(posedge clk_i);
        last_lo = 0;
        p.flash(3);
        repeat (30) @(posedge clk_i);
        check(uart_serial_out_o, 1'b1);
        check(last_lo, 0);
        decoder_reset_n_i <= 1'b1;
        // Slow rate: four quick starts, one busy, two buffered, last refused
        rate_select_i <= 3'h6;
        @(posedge clk_i);
        npulse = 0;
        p.send_bits(8'hAA, 8, 2);
        @(posedge clk_i);
        check(tx_event_ready_o, 1'b0);
        for (int i = 0; i < 6000 && tx_event_ready_o !== 1'b1; i++) @(posedge clk_i);
        check(tx_event_ready_o, 1'b1);
        if (tx_event_ready_o === 1'b1) begin
            repeat (4000) @(posedge clk_i);
            check(npulse, 3);
        end
        summarize();
    end
endmodule : testbench
`default_nettype wire
